// *** verilog/ict_pkg.sv ***
// package: constants and types of the instruction cycle timer
// assumes: one 100 MHz system clock, no software registers
package ict_pkg;
  localparam int          PHASE_COUNT  = 4;
  localparam logic [1:0]  PHASE_LAST   = 2'h3;
  localparam logic [1:0]  PHASE_RESET  = 2'h0;
  localparam int          CLK_PERIOD_NS = 10;

  // instruction class reported by the decoder
  typedef enum logic [2:0] {
    ICT_OP_PLAIN,
    ICT_OP_JUMP,
    ICT_OP_CALL,
    ICT_OP_RET,
    ICT_OP_RETURN_FROM_INTERRUPT,
    ICT_OP_TABLE,
    ICT_OP_SKIP
  } ict_op_t;

  typedef enum logic {
    ICT_ST_FIRST,
    ICT_ST_EXTRA
  } ict_state_t;
endpackage : ict_pkg

// *** verilog/ict_phase_if.sv ***
// interface: phase strobes between the divider and the sequencer
// assumes: both ends on mclk
`timescale 1ns/1ps
interface ict_phase_if;
  logic [1:0] phase;
  logic       cycleEnd;
  modport gen (output phase, output cycleEnd);
  modport use_ (input phase, input cycleEnd);
endinterface : ict_phase_if

// *** verilog/ict_phase_gen.sv ***
// divider: splits mclk into four phases, cycleEnd on the last
// assumes: mclk, async active-low reset
`timescale 1ns/1ps
module ict_phase_gen
  import ict_pkg::*;
(
  // clock and reset
  input  wire logic  mclk,
  input  wire logic  nrst,
  // phase strobes
  ict_phase_if.gen   ph
);
  typedef struct packed {
    logic [1:0] phase;
  } ict_gen_state_t;

  ict_gen_state_t s_q;
  ict_gen_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.phase = (s_q.phase == PHASE_LAST) ? PHASE_RESET : 2'(s_q.phase + 2'h1);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{phase: PHASE_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  assign ph.phase    = s_q.phase;
  assign ph.cycleEnd = (s_q.phase == PHASE_LAST);

  // one end strobe every four clocks
  period_four_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd |=> !ph.cycleEnd [*3] ##1 ph.cycleEnd) else $error("cycle end not every fourth clock");
endmodule : ict_phase_gen

// *** verilog/ict_sequencer.sv ***
// top: instruction cycle sequencer of the small core
// assumes: decoder inputs come from mclk logic, stable through the instruction cycle
// Operation
// - each instruction cycle lasts exactly four system clocks and sequencing advances once per four.
// - plain non-branching instructions finish in one instruction cycle.
// - jump, call, return, return from interrupt and table read take two cycles, the extra after the first.
// - an instruction writing the program counter low byte acts as a jump and takes one extra cycle.
// - a skip takes one cycle when not taken and two, discarding the next instruction, when taken.
`timescale 1ns/1ps
module ict_sequencer
  import ict_pkg::*;
(
  // clock and reset
  input  wire logic           mclk,
  input  wire logic           nrst,
  // decoded instruction
  input  wire ict_pkg::ict_op_t opClass,
  input  wire logic           writesPcLow,
  input  wire logic           skipTaken,
  // timing outputs
  output logic [1:0]          phase,
  output logic                cycleEnd,
  output logic                execEnable,
  output logic                instrDone,
  output logic                flushFetch,
  output logic                inExtraCycle
);
  ict_phase_if ph ();

  ict_phase_gen u_gen (
    .mclk (mclk),
    .nrst (nrst),
    .ph   (ph.gen)
  );

  typedef struct packed {
    ict_state_t st;
    logic       done;
    logic       flush;
  } ict_seq_state_t;

  ict_seq_state_t s_q;
  ict_seq_state_t s_d;

  // two-cycle classes; plain and untaken skips stay at one unless they write the program counter low byte
  function automatic logic needs_extra(ict_op_t op, logic program_counter_low_byte, logic skip);
    logic r;
    r = 1'b0;
    unique case (op)
      ICT_OP_JUMP, ICT_OP_CALL, ICT_OP_RET, ICT_OP_RETURN_FROM_INTERRUPT, ICT_OP_TABLE: r = 1'b1;
      ICT_OP_SKIP:  r = skip;
      ICT_OP_PLAIN: r = 1'b0;
      default:      r = 1'b0;
    endcase
    return r | program_counter_low_byte;
  endfunction : needs_extra

  logic extra;
  assign extra = needs_extra(opClass, writesPcLow, skipTaken);

  always_comb begin
    s_d = s_q;
    s_d.done  = 1'b0;
    s_d.flush = 1'b0;
    if (ph.cycleEnd) begin
      unique case (s_q.st)
        ICT_ST_FIRST: begin
          if (extra) begin
            s_d.st    = ICT_ST_EXTRA;
            s_d.flush = 1'b1;
          end else begin
            s_d.done = 1'b1;
          end
        end
        ICT_ST_EXTRA: begin
          s_d.st   = ICT_ST_FIRST;
          s_d.done = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: ICT_ST_FIRST, done: 1'b0, flush: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // suppressed fetch shows as no execution for the whole extra cycle
  assign phase        = ph.phase;
  assign cycleEnd     = ph.cycleEnd;
  assign inExtraCycle = (s_q.st == ICT_ST_EXTRA);
  assign execEnable   = (s_q.st == ICT_ST_FIRST);
  assign instrDone    = s_q.done;
  assign flushFetch   = s_q.flush;

  // cycle framing: the sequencer state moves on the last phase only; done and flush rise with it
  state_steps_a : assert property (@(posedge mclk) disable iff (!nrst)
    !ph.cycleEnd |=> $stable(s_q.st)) else $error("state moved off cycle end");

  done_phase_a : assert property (@(posedge mclk) disable iff (!nrst)
    instrDone |-> ph.phase == PHASE_RESET && $past(ph.cycleEnd)) else $error("done off the cycle boundary");

  done_spacing_a : assert property (@(posedge mclk) disable iff (!nrst)
    instrDone |=> !instrDone [*3]) else $error("done closer than four clocks");

  extra_start_a : assert property (@(posedge mclk) disable iff (!nrst)
    $rose(inExtraCycle) |-> ph.phase == PHASE_RESET) else $error("extra cycle off the cycle boundary");

  // one-cycle classes; stray codes must not stall the core
  plain_one_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && opClass == ICT_OP_PLAIN && !writesPcLow
    |=> instrDone && !inExtraCycle) else $error("plain instruction not one cycle");

  odd_code_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && !writesPcLow
    && !(opClass inside {ICT_OP_PLAIN, ICT_OP_JUMP, ICT_OP_CALL, ICT_OP_RET, ICT_OP_RETURN_FROM_INTERRUPT, ICT_OP_TABLE, ICT_OP_SKIP})
    |=> instrDone && execEnable) else $error("undefined class code not one cycle");

  // two-cycle classes
  branch_two_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && opClass inside {ICT_OP_JUMP, ICT_OP_CALL, ICT_OP_RET,
      ICT_OP_RETURN_FROM_INTERRUPT, ICT_OP_TABLE}
    |=> inExtraCycle [*4] ##1 !inExtraCycle && instrDone) else $error("branch not two cycles");

  extra_once_a : assert property (@(posedge mclk) disable iff (!nrst)
    inExtraCycle && ph.cycleEnd |=> !inExtraCycle && instrDone) else $error("extra cycle not single");

  pcl_write_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && writesPcLow |=> inExtraCycle && !instrDone)
    else $error("low byte write missed extra cycle");

  pcl_two_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && writesPcLow
    |=> inExtraCycle [*4] ##1 !inExtraCycle && instrDone) else $error("low byte write not two cycles");

  // skips: a taken skip, or one writing the program counter low byte, costs the extra cycle
  skip_taken_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && opClass == ICT_OP_SKIP && !writesPcLow
    |=> inExtraCycle == $past(skipTaken)) else $error("skip timing wrong");

  skip_plain_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && opClass == ICT_OP_SKIP && !skipTaken && !writesPcLow
    |=> instrDone && execEnable) else $error("untaken skip not one cycle");

  skip_two_a : assert property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && s_q.st == ICT_ST_FIRST && opClass == ICT_OP_SKIP && skipTaken
    |=> inExtraCycle [*4] ##1 !inExtraCycle && instrDone) else $error("taken skip not two cycles");

  // fetched word dropped once, execution back after the extra cycle
  extra_flush_a : assert property (@(posedge mclk) disable iff (!nrst)
    $rose(inExtraCycle) |-> flushFetch && !execEnable) else $error("extra cycle without flush");

  flush_pulse_a : assert property (@(posedge mclk) disable iff (!nrst)
    flushFetch |=> !flushFetch) else $error("flush longer than one clock");

  flush_place_a : assert property (@(posedge mclk) disable iff (!nrst)
    flushFetch |-> $rose(inExtraCycle)) else $error("flush outside extra cycle start");

  exec_resume_a : assert property (@(posedge mclk) disable iff (!nrst)
    $fell(inExtraCycle) |-> execEnable && instrDone) else $error("execution not resumed after extra cycle");

  cov_plain_c  : cover property (@(posedge mclk) disable iff (!nrst) instrDone && !$past(inExtraCycle));
  cov_branch_c : cover property (@(posedge mclk) disable iff (!nrst) $fell(inExtraCycle));
  cov_skip_c   : cover property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && opClass == ICT_OP_SKIP && skipTaken && s_q.st == ICT_ST_FIRST);
  cov_pcl_c    : cover property (@(posedge mclk) disable iff (!nrst)
    ph.cycleEnd && writesPcLow && opClass == ICT_OP_PLAIN && s_q.st == ICT_ST_FIRST);
  cov_back_c   : cover property (@(posedge mclk) disable iff (!nrst) instrDone ##4 instrDone);
endmodule : ict_sequencer

// *** dv/instruction_cycle_timing_bench.sv ***
// bench: drives decoded classes, checks cycle timing
// assumes: ict_sequencer top, mclk 100 MHz
`timescale 1ns/1ps
module instruction_cycle_timing_bench;
  import ict_pkg::*;
  logic       mclk, nrst, writesPcLow, skipTaken;
  ict_op_t    opClass;
  logic [1:0] phase;
  logic       cycleEnd, execEnable, instrDone, flushFetch, inExtraCycle;
  int         n_fail = 0;
  int         check_count = 0;

  ict_sequencer dut (.mclk(mclk), .nrst(nrst), .opClass(opClass), .writesPcLow(writesPcLow),
    .skipTaken(skipTaken), .phase(phase), .cycleEnd(cycleEnd), .execEnable(execEnable),
    .instrDone(instrDone), .flushFetch(flushFetch), .inExtraCycle(inExtraCycle));

  initial begin
    mclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) mclk = ~mclk;
  end

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  // status nibble: execEnable, instrDone, flushFetch, inExtraCycle
  task automatic run_op(input ict_op_t op, input logic wp, input logic sk, input logic extra);
    @(posedge mclk);
    opClass     <= op;
    writesPcLow <= wp;
    skipTaken   <= sk;
    @(negedge mclk);
    for (int n = 0; n < 12 && !(cycleEnd === 1'b1 && inExtraCycle === 1'b0); n++) @(negedge mclk);
    @(negedge mclk);
    chk({2'h0, phase}, 4'h0);
    chk({execEnable, instrDone, flushFetch, inExtraCycle}, extra ? 4'h3 : 4'hC);
    if (extra) begin
      @(negedge mclk);
      chk({execEnable, instrDone, flushFetch, inExtraCycle}, 4'h1);
      repeat (PHASE_COUNT - 1) @(negedge mclk);
      chk({execEnable, instrDone, flushFetch, inExtraCycle}, 4'hC);
    end
  endtask : run_op

  task automatic test_reset;
    @(negedge mclk);
    chk({execEnable, instrDone, flushFetch, inExtraCycle}, 4'h8);
    @(posedge mclk) nrst <= 1'b1;
    repeat (2) @(negedge mclk);
    chk({2'h0, phase}, 4'h1);
    @(negedge mclk);
    chk({3'h0, cycleEnd}, 4'h0);
    @(negedge mclk);
    chk({3'h0, cycleEnd}, 4'h1);
  endtask : test_reset

  // two-cycle classes, back to back; ict_op_t codes 1..5
  task automatic test_branches;
    for (int i = 1; i <= 5; i++) run_op(ict_op_t'(i), 1'b0, 1'b0, 1'b1);
  endtask : test_branches

  // plain, stray code 7, and a skip flag on a non-skip
  task automatic test_plain;
    run_op(ICT_OP_PLAIN, 1'b0, 1'b0, 1'b0);
    run_op(ICT_OP_PLAIN, 1'b0, 1'b0, 1'b0);
    run_op(ict_op_t'(3'h7), 1'b0, 1'b0, 1'b0);
    run_op(ICT_OP_PLAIN, 1'b0, 1'b1, 1'b0);
  endtask : test_plain

  task automatic test_pcl_write;
    run_op(ICT_OP_PLAIN, 1'b1, 1'b0, 1'b1);
    run_op(ICT_OP_TABLE, 1'b1, 1'b0, 1'b1);
  endtask : test_pcl_write

  task automatic test_skip;
    run_op(ICT_OP_SKIP, 1'b0, 1'b0, 1'b0);
    run_op(ICT_OP_SKIP, 1'b0, 1'b1, 1'b1);
  endtask : test_skip

  // reset dropped inside an extra cycle must clear it at once
  task automatic test_mid_reset;
    @(posedge mclk);
    opClass     <= ICT_OP_JUMP;
    writesPcLow <= 1'b0;
    skipTaken   <= 1'b0;
    @(negedge mclk);
    for (int n = 0; n < 12 && !(cycleEnd === 1'b1 && inExtraCycle === 1'b0); n++) @(negedge mclk);
    @(negedge mclk);
    chk({execEnable, instrDone, flushFetch, inExtraCycle}, 4'h3);
    @(posedge mclk) nrst <= 1'b0;
    @(negedge mclk);
    chk({execEnable, instrDone, flushFetch, inExtraCycle}, 4'h8);
    chk({2'h0, phase}, 4'h0);
    @(posedge mclk) begin
      nrst    <= 1'b1;
      opClass <= ICT_OP_PLAIN;
    end
    repeat (2) @(negedge mclk);
    chk({2'h0, phase}, 4'h1);
  endtask : test_mid_reset

  initial begin
    nrst        = 1'b0;
    opClass     = ICT_OP_PLAIN;
    writesPcLow = 1'b0;
    skipTaken   = 1'b0;
    repeat (10) @(posedge mclk);
    test_reset();
    test_plain();
    test_branches();
    test_pcl_write();
    test_skip();
    test_mid_reset();
    run_op(ICT_OP_PLAIN, 1'b0, 1'b0, 1'b0);
    report_and_stop();
  end

  // whole run needs under 200 clocks; limit is ten times that
  initial begin
    #(2000 * CLK_PERIOD_NS);
    n_fail++;
    report_and_stop();
  end
endmodule : instruction_cycle_timing_bench
